//--- design/pdlc_pkg.sv
/*
  pdlc_pkg: constants for the synthesizer digital control block: register
  addresses, field positions, reset values, lock counts and power timing.
  Assumes a 20 MHz control clock (mclk) and 20-bit register words.
*/
package pdlc_pkg;
  // word addresses carried on the load port
  localparam logic [3:0] PDLC_ADDR_AB = 4'h1;
  localparam logic [3:0] PDLC_ADDR_CP = 4'h2;
  localparam logic [3:0] PDLC_ADDR_REFPRE = 4'h3;
  localparam logic [3:0] PDLC_ADDR_FUNC = 4'h4;
  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int PDLC_A_LSB = 0;
  localparam int PDLC_B_LSB = 6;
  localparam int PDLC_CP1_LSB = 0;
  localparam int PDLC_CP2_LSB = 6;
  localparam int PDLC_R_LSB = 0;
  localparam int PDLC_PRE_LSB = 14;
  localparam int PDLC_FAST_LSB = 0;
  localparam int PDLC_LDSEL_BIT = 13;
  localparam int PDLC_FAST_LOCK_ARM_BIT_BIT = 16;
  localparam int PDLC_LDCNT_LSB = 17;
  ////////////////////////////////////////////////////////////////////////////
  // reset values (real part leaves them undefined; zero chosen)
  localparam logic [19:0] PDLC_WORD_RST = 20'h00000;
  localparam logic [3:0] PDLC_CP_HALF = 4'h8;
  // lock counts for select codes 00..11
  localparam logic [5:0] PDLC_LDN0 = 6'h07;
  localparam logic [5:0] PDLC_LDN1 = 6'h0F;
  localparam logic [5:0] PDLC_LDN2 = 6'h1F;
  localparam logic [5:0] PDLC_LDN3 = 6'h3F;
  // register access allowed this long after core enable rises
  localparam int PDLC_WRITE_WAIT_NS = 50000;
  localparam int PDLC_CLK_NS = 50;
  localparam int PDLC_WRITE_WAIT_CYC = (PDLC_WRITE_WAIT_NS + PDLC_CLK_NS - 1) / PDLC_CLK_NS;
  typedef enum logic [1:0] {
    PDLC_PWR_DOWN = 2'b00,
    PDLC_PWR_BAD = 2'b01,
    PDLC_PWR_SAVE = 2'b10,
    PDLC_PWR_NORMAL = 2'b11
  } pdlc_pwr_t;
endpackage : pdlc_pkg

//--- design/pdlc_div.sv
/*
  pdlc_div: one programmable up-count divider; emits a one-cycle tick each
  time ratio input edges (enables) have been counted.
  Assumes ratio >= 1 and that the enable is a one-cycle pulse per input edge.
*/
`timescale 1ns/100ps
module pdlc_div (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic step,
  input wire logic [13:0] ratio,
  output logic tick
);
  import pdlc_pkg::*;
  logic [13:0] cnt_q;
  // count up; clear to zero on terminal count or on restart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 14'h0000;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_q <= 14'h0000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (step) begin
        if (cnt_q + 14'h0001 >= ratio) begin
          cnt_q <= 14'h0000;
          tick <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 14'h0001;
        end
      end
    end
  end
endmodule : pdlc_div

//--- design/pdlc_fbdiv.sv
/*
  pdlc_fbdiv: dual-modulus prescaler with swallow and main counters. Each
  rf_step is one prescaler input edge; fb_tick pulses once per N = P*B + A.
  Assumes B >= 3 and B >= A, kept by the host.
*/
`timescale 1ns/100ps
module pdlc_fbdiv (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic rf_step,
  input wire logic [6:0] pmod,
  input wire logic [5:0] swallow,
  input wire logic [12:0] main_cnt,
  output logic fb_tick
);
  import pdlc_pkg::*;
  logic [6:0] pre_q;
  logic [5:0] a_q;
  logic [12:0] b_q;
  logic [6:0] pre_end;
  // modulus P+1 while swallow runs, else P
  assign pre_end = (a_q != 6'h00) ? pmod : pmod - 7'h01;
  ////////////////////////////////////////////////////////////////////////////
  // prescaler cycle drives swallow and main counters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 7'h00;
      a_q <= 6'h00;
      b_q <= 13'h0000;
      fb_tick <= 1'b0;
    end else if (restart) begin
      pre_q <= 7'h00;
      a_q <= swallow;
      b_q <= 13'h0000;
      fb_tick <= 1'b0;
    end else begin
      fb_tick <= 1'b0;
      if (rf_step) begin
        if (pre_q >= pre_end) begin
          pre_q <= 7'h00;
          if (a_q != 6'h00) begin
            a_q <= a_q - 6'h01;
          end
          if (b_q + 13'h0001 >= main_cnt) begin
            b_q <= 13'h0000;
            a_q <= swallow;
            fb_tick <= 1'b1;
          end else begin
            b_q <= b_q + 13'h0001;
          end
        end else begin
          pre_q <= pre_q + 7'h01;
        end
      end
    end
  end
endmodule : pdlc_fbdiv

//--- design/pdlc_top.sv
/*
  pdlc_top: digital control of an integer-N synthesizer: buffered divider
  words, reference and feedback dividers, fast-lock timer, lock detect and
  power pins. Assumes words arrive already deserialised with an address and
  a one-cycle load pulse (the load strobe rising edge), and that reference
  and RF input edges arrive as one-cycle step pulses synchronous to mclk.
*/
// How it works
// - feedback ratio is prescaler modulus times main count plus swallow
// - comparison rate is the reference input divided by reference divider
// - swallow is six bits, host keeps it at or below main count
// - fast lock armed only while function bit 16 is one
// - fast lock starts on divider word load or active-mode pin rise
// - during timer, loop-filter switch closed and fast pump code used
// - after timer, switch opens and normal pump code returns
// - timer length is fast count times comparison periods
// - codes 0 to 7 give min times code plus one, 8 gives half
// - bit 13 set routes raw comparator to lock pin, else filtered
// - digital lock pin goes low on every new frequency
// - lock pin rises after N consecutive small phase errors
// - lock pin falls after N consecutive large phase errors
// - lock count select 00,01,10,11 gives 7,15,31,63
// - prescaler select 01,10,11 gives 16,32,64; 00 prohibited
// - pin pair selects power down, save or normal; one pair prohibited
// - writes wait 50 us after core enable; pump hi-z in power save
// - registers kept when active mode drops during normal operation
// - pump and reference words buffered, committed on divider word load
`timescale 1ns/100ps
module pdlc_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load_strobe,
  input wire logic [3:0] load_addr,
  input wire logic [19:0] load_data,
  input wire logic core_power_enable_pin,
  input wire logic active_mode_pin,
  input wire logic ref_step,
  input wire logic rf_step,
  input wire logic phase_err_small,
  input wire logic phase_cmp_raw,
  output logic phase_comparison_rate,
  output logic fb_compare_tick,
  output logic loop_filter_switch_pin,
  output logic [4:0] pump_current_units,
  output logic pump_enable,
  output logic lock_indicator,
  output logic fast_lock_active,
  output logic write_ready,
  output logic pwr_prohibited
);
  import pdlc_pkg::*;
  logic [19:0] cp_buf_q, rp_buf_q, cp_q, rp_q, ab_q, func_q;
  logic commit_q, commit_d, act_q, act_rise, ref_tick, fb_tick;
  logic [12:0] fast_q;
  logic [5:0] ld_cnt_q, ld_n;
  logic locked_q, ld_dig_q;
  logic [15:0] wait_q;
  logic [6:0] pmod;
  logic [3:0] code_sel;
  logic stamp_ok;
  pdlc_pwr_t pwr;
  assign pwr = pdlc_pwr_t'({core_power_enable_pin, active_mode_pin});
  // accept only while the registered ready flag shows, so the host never
  // sees a word taken a cycle before write_ready admits it
  assign stamp_ok = core_power_enable_pin && write_ready;
  ////////////////////////////////////////////////////////////////////////////
  // power-up wait count; writes before it expire are dropped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 16'h0000;
    end else if (!core_power_enable_pin) begin
      wait_q <= 16'h0000;
    end else if (wait_q != 16'(PDLC_WRITE_WAIT_CYC)) begin
      wait_q <= wait_q + 16'h0001;
    end
  end
  // word buffers; only the divider word commits the pump and reference
  // words. contents survive power save since nothing here clears them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cp_buf_q <= PDLC_WORD_RST;
      rp_buf_q <= PDLC_WORD_RST;
      cp_q <= PDLC_WORD_RST;
      rp_q <= PDLC_WORD_RST;
      ab_q <= PDLC_WORD_RST;
      func_q <= PDLC_WORD_RST;
    end else if (load_strobe && stamp_ok) begin
      if (load_addr == PDLC_ADDR_AB) begin
        ab_q <= load_data;
        cp_q <= cp_buf_q;
        rp_q <= rp_buf_q;
      end else if (load_addr == PDLC_ADDR_CP) begin
        cp_buf_q <= load_data;
      end else if (load_addr == PDLC_ADDR_REFPRE) begin
        rp_buf_q <= load_data;
      end else if (load_addr == PDLC_ADDR_FUNC) begin
        func_q <= load_data;
      end
    end
  end
  assign commit_d = load_strobe && stamp_ok && (load_addr == PDLC_ADDR_AB);
  // registered commit and active-mode edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      commit_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      commit_q <= commit_d;
      act_q <= active_mode_pin;
    end
  end
  assign act_rise = active_mode_pin && !act_q && core_power_enable_pin;
  ////////////////////////////////////////////////////////////////////////////
  // prescaler modulus; prohibited code 00 falls back to 16
  always_comb begin
    case (rp_q[PDLC_PRE_LSB +: 2])
      2'b10: pmod = 7'h20;
      2'b11: pmod = 7'h40;
      default: pmod = 7'h10;
    endcase
  end
  pdlc_div u_ref (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(commit_q),
    .step(ref_step),
    .ratio(rp_q[PDLC_R_LSB +: 14]),
    .tick(ref_tick)
  );
  pdlc_fbdiv u_fb (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(commit_q),
    .rf_step(rf_step),
    .pmod(pmod),
    .swallow(ab_q[PDLC_A_LSB +: 6]),
    .main_cnt(ab_q[PDLC_B_LSB +: 13]),
    .fb_tick(fb_tick)
  );
  ////////////////////////////////////////////////////////////////////////////
  // fast-lock timer counts comparison periods
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fast_q <= 13'h0000;
    end else if (!func_q[PDLC_FAST_LOCK_ARM_BIT_BIT]) begin
      fast_q <= 13'h0000;
    end else if (commit_q || act_rise) begin
      fast_q <= func_q[PDLC_FAST_LSB +: 13];
    end else if (ref_tick && fast_q != 13'h0000) begin
      fast_q <= fast_q - 13'h0001;
    end
  end
  // fast code while timer runs, normal code after
  assign code_sel = (fast_q != 13'h0000) ? cp_q[PDLC_CP2_LSB +: 4]
                                         : cp_q[PDLC_CP1_LSB +: 4];
  // pump outputs in units of half the minimum current
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pump_current_units <= 5'h00;
      loop_filter_switch_pin <= 1'b0;
      fast_lock_active <= 1'b0;
      pump_enable <= 1'b0;
    end else begin
      loop_filter_switch_pin <= (fast_q != 13'h0000);
      fast_lock_active <= (fast_q != 13'h0000);
      pump_enable <= (pwr == PDLC_PWR_NORMAL);
      if (code_sel[3]) begin
        pump_current_units <= 5'h01;
      end else begin
        pump_current_units <= {code_sel[2:0] + 3'h1 == 3'h0, code_sel[2:0] + 3'h1, 1'b0};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // lock count select
  always_comb begin
    case (func_q[PDLC_LDCNT_LSB +: 2])
      2'b00: ld_n = PDLC_LDN0;
      2'b01: ld_n = PDLC_LDN1;
      2'b10: ld_n = PDLC_LDN2;
      default: ld_n = PDLC_LDN3;
    endcase
  end
  // digital lock filter, one decision per comparison
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ld_cnt_q <= 6'h00;
      locked_q <= 1'b0;
    end else if (commit_q) begin
      ld_cnt_q <= 6'h00;
      locked_q <= 1'b0;
    end else if (ref_tick) begin
      if (phase_err_small == locked_q) begin
        ld_cnt_q <= 6'h00;
      end else if (ld_cnt_q + 6'h01 >= ld_n) begin
        ld_cnt_q <= 6'h00;
        locked_q <= !locked_q;
      end else begin
        ld_cnt_q <= ld_cnt_q + 6'h01;
      end
    end
  end
  assign ld_dig_q = locked_q;
  // lock pin source select
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lock_indicator <= 1'b0;
    end else begin
      lock_indicator <= func_q[PDLC_LDSEL_BIT] ? phase_cmp_raw : ld_dig_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // status outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_comparison_rate <= 1'b0;
      fb_compare_tick <= 1'b0;
      write_ready <= 1'b0;
      pwr_prohibited <= 1'b0;
    end else begin
      phase_comparison_rate <= ref_tick;
      fb_compare_tick <= fb_tick;
      write_ready <= core_power_enable_pin && (wait_q == 16'(PDLC_WRITE_WAIT_CYC));
      pwr_prohibited <= (pwr == PDLC_PWR_BAD);
    end
  end
endmodule : pdlc_top

//--- bench/pdlc_top_props.sv
/*
  pdlc_top_props: port-level checks for pdlc_top, bound to every instance.
  Assumes the one clock mclk and the asynchronous active-low rst_n.
*/
`timescale 1ns/100ps
module pdlc_top_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load_strobe,
  input wire logic [3:0] load_addr,
  input wire logic [19:0] load_data,
  input wire logic core_power_enable_pin,
  input wire logic active_mode_pin,
  input wire logic phase_cmp_raw,
  input wire logic phase_comparison_rate,
  input wire logic loop_filter_switch_pin,
  input wire logic pump_enable,
  input wire logic lock_indicator,
  input wire logic write_ready,
  input wire logic pwr_prohibited
);
  import pdlc_pkg::*;
  logic [19:0] func_q;
  // shadow of the function word; it acts at once, no commit needed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= PDLC_WORD_RST;
    end else if (load_strobe && write_ready && core_power_enable_pin &&
                 load_addr == PDLC_ADDR_FUNC) begin
      func_q <= load_data;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // accepted divider word, i.e. a new frequency
  sequence s_load;
    load_strobe && write_ready && core_power_enable_pin && load_addr == PDLC_ADDR_AB;
  endsequence
  property p_drop; s_load ##0 !func_q[PDLC_LDSEL_BIT] |-> ##3 !lock_indicator; endproperty
  a_drop: assert property (p_drop) else $error("lock kept on load");
  property p_fast; s_load ##0 (func_q[16] && func_q[12:0] != 13'h0) |-> ##3 loop_filter_switch_pin;
  endproperty
  a_fast: assert property (p_fast) else $error("no fast lock");
  property p_arm; $rose(loop_filter_switch_pin) |-> func_q[PDLC_FAST_LOCK_ARM_BIT_BIT]; endproperty
  a_arm: assert property (p_arm) else $error("fast lock unarmed");
  property p_rate; phase_comparison_rate |=> !phase_comparison_rate; endproperty
  a_rate: assert property (p_rate) else $error("rate pulse long");
  property p_ban; active_mode_pin && !core_power_enable_pin |=> pwr_prohibited; endproperty
  a_ban: assert property (p_ban) else $error("bad pair missed");
  property p_hiz; !active_mode_pin |=> !pump_enable; endproperty
  a_hiz: assert property (p_hiz) else $error("pump on in save");
  property p_ready; !core_power_enable_pin |=> !write_ready; endproperty
  a_ready: assert property (p_ready) else $error("ready while off");
  property p_raw;
    (func_q[PDLC_LDSEL_BIT] && $stable(phase_cmp_raw)) [*3] |-> lock_indicator == phase_cmp_raw;
  endproperty
  a_raw: assert property (p_raw) else $error("raw lock wrong");
endmodule : pdlc_top_props
bind pdlc_top pdlc_top_props pdlc_top_props_i (.*);

//--- bench/pdlc_host.sv
/*
  pdlc_host: host model that hands whole words and power pin moves over.
  Assumes the bench calls its tasks and honours write_ready itself.
*/
`timescale 1ns/100ps
module pdlc_host (
  input wire logic mclk,
  output logic load_strobe,
  output logic [3:0] load_addr,
  output logic [19:0] load_data,
  output logic core_power_enable_pin,
  output logic active_mode_pin
);
  // all idle at time zero
  initial begin
    load_strobe = 1'b0;
    load_addr = 4'h0;
    load_data = 20'h00000;
    core_power_enable_pin = 1'b0;
    active_mode_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // one whole word a strobe; the bus is scrambled once released
  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    @(posedge mclk);
    load_strobe <= 1'b1;
    load_addr <= a;
    load_data <= d;
    @(posedge mclk);
    load_strobe <= 1'b0;
    load_data <= ~d;
  endtask : wr
  // core up before active, active down before core
  task automatic pw(input logic c, input logic a);
    @(posedge mclk);
    if (c) begin
      core_power_enable_pin <= 1'b1;
      @(posedge mclk);
      active_mode_pin <= a;
    end else begin
      active_mode_pin <= a;
      @(posedge mclk);
      core_power_enable_pin <= 1'b0;
    end
  endtask : pw
endmodule : pdlc_host

//--- bench/pdlc_top_tb.sv
/*
  pdlc_top_tb: self-checking bench for pdlc_top driven through pdlc_host.
  Assumes a 20 MHz mclk; steps run one per cycle once programmed.
*/
`timescale 1ns/100ps
module pdlc_top_tb;
  import pdlc_pkg::*;
  logic mclk, rst_n, ref_step, rf_step, phase_err_small, phase_cmp_raw;
  logic load_strobe, core_power_enable_pin, active_mode_pin, pump_enable;
  logic phase_comparison_rate, fb_compare_tick, loop_filter_switch_pin;
  logic lock_indicator, fast_lock_active, write_ready, pwr_prohibited;
  logic [3:0] load_addr, c2;
  logic [19:0] load_data;
  logic [4:0] pump_current_units;
  logic [31:0] seed;
  int err_count, check_count, n;
  int bv[4] = '{0, 3, 63, 100};
  int av[4] = '{0, 3, 63, 0};
  pdlc_top pdlc_top_i (.*);
  pdlc_host pdlc_host_i (.*);
  always #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // model of the pump in half-minimum units; 1xxx means half
  function automatic logic [31:0] u(input logic [3:0] c);
    return c[3] ? 32'h1 : 32'(2 * (c[2:0] + 1));
  endfunction : u
  function automatic logic [19:0] fw(input logic [1:0] s, input logic en, input logic ld);
    return {1'b0, s, en, 2'b00, ld, 13'h0003};
  endfunction : fw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic st(input int k);
    repeat (k) @(posedge mclk);
    @(negedge mclk);
  endtask : st
  // rate ticks seen until the switch or lock pin reaches lvl
  task automatic cnt(input logic sw, input logic lvl, output int c);
    c = 0;
    repeat (3000) begin
      @(negedge mclk);
      if ((sw ? loop_filter_switch_pin : lock_indicator) === lvl) break;
      if (phase_comparison_rate === 1'b1) c++;
    end
  endtask : cnt
  // cycles between two ticks of the feedback or reference divider
  task automatic gap(input logic f, output int g);
    int s;
    s = 0;
    g = 0;
    repeat (20000) begin
      @(negedge mclk);
      if (s == 1) g++;
      if ((f ? fb_compare_tick : phase_comparison_rate) === 1'b1) s++;
      if (s == 2) break;
    end
  endtask : gap
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // hang guard, about three times the expected run
  initial begin
    #3000000;
    err_count++;
    close_out();
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    ref_step = 1'b0;
    rf_step = 1'b0;
    phase_err_small = 1'b0;
    phase_cmp_raw = 1'b0;
    seed = 32'h4F1A;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    st(0);
    chk({pump_enable, loop_filter_switch_pin}, 0);
    pdlc_host_i.pw(1'b1, 1'b0);
    st(PDLC_WRITE_WAIT_CYC - 50);
    chk(write_ready, 0);
    st(60);
    chk({write_ready, pump_enable}, 2);
    // normal, the banned pair, then power down
    for (int i = 0; i < 3; i++) begin
      pdlc_host_i.pw(i == 0, i < 2);
      st(3);
      chk({pwr_prohibited, pump_enable}, {i == 1, i == 0});
    end
    // a word sent too early must be dropped
    pdlc_host_i.pw(1'b1, 1'b0);
    pdlc_host_i.wr(PDLC_ADDR_FUNC, fw(2'b00, 1'b1, 1'b1));
    st(PDLC_WRITE_WAIT_CYC + 10);
    @(posedge mclk);
    phase_cmp_raw <= 1'b1;
    st(3);
    chk(lock_indicator, 0);
    pdlc_host_i.pw(1'b1, 1'b1);
    pdlc_host_i.wr(PDLC_ADDR_CP, 20'h00008);
    pdlc_host_i.wr(PDLC_ADDR_REFPRE, 20'h04008);
    pdlc_host_i.wr(PDLC_ADDR_FUNC, fw(2'b00, 1'b1, 1'b0));
    pdlc_host_i.wr(PDLC_ADDR_AB, 20'h000C2);
    @(posedge mclk);
    ref_step <= 1'b1;
    rf_step <= 1'b1;
    phase_cmp_raw <= 1'b0;
    // the switch only closes two cycles after the commit
    st(1);
    chk({loop_filter_switch_pin, fast_lock_active}, 3);
    cnt(1'b1, 1'b0, n);
    chk(n, 3);
    for (int i = 0; i < 9; i++) begin
      seed = nx(seed);
      c2 = seed[3:0];
      pdlc_host_i.wr(PDLC_ADDR_CP, {10'h000, c2, 2'b00, 4'(i)});
      st(3);
      chk(pump_current_units, u(i == 0 ? 4'h8 : 4'(i - 1)));
      pdlc_host_i.wr(PDLC_ADDR_AB, 20'h000C2);
      st(3);
      chk({loop_filter_switch_pin, pump_current_units}, 32'h20 | u(c2));
      cnt(1'b1, 1'b0, n);
      chk(n, 3);
      st(1);
      chk({fast_lock_active, pump_current_units}, u(4'(i)));
    end
    for (int p = 1; p < 4; p++) begin
      pdlc_host_i.wr(PDLC_ADDR_REFPRE, {4'h0, 2'(p), 14'h0008});
      pdlc_host_i.wr(PDLC_ADDR_AB, {1'b0, 13'(bv[p]), 6'(av[p])});
      st(3);
      gap(1'b1, n);
      chk(n, (8 << p) * bv[p] + av[p]);
    end
    gap(1'b0, n);
    chk(n, 8);
    for (int s = 0; s < 4; s++) begin
      pdlc_host_i.wr(PDLC_ADDR_FUNC, fw(2'(s), 1'b0, 1'b0));
      pdlc_host_i.wr(PDLC_ADDR_AB, 20'h000C2);
      st(3);
      chk({loop_filter_switch_pin, lock_indicator}, 0);
      @(posedge mclk);
      phase_err_small <= 1'b1;
      cnt(1'b0, 1'b1, n);
      chk(n, (8 << s) - 1);
      @(posedge mclk);
      phase_err_small <= 1'b0;
      cnt(1'b0, 1'b0, n);
      chk(n, (8 << s) - 1);
    end
    // relock, then a new frequency must drop the pin at once
    @(posedge mclk);
    phase_err_small <= 1'b1;
    cnt(1'b0, 1'b1, n);
    chk(n, 63);
    pdlc_host_i.wr(PDLC_ADDR_AB, 20'h000C2);
    st(3);
    chk(lock_indicator, 0);
    pdlc_host_i.wr(PDLC_ADDR_FUNC, fw(2'b00, 1'b1, 1'b0));
    pdlc_host_i.pw(1'b1, 1'b0);
    pdlc_host_i.pw(1'b1, 1'b1);
    st(3);
    chk({loop_filter_switch_pin, pump_current_units}, 32'h20 | u(c2));
    pdlc_host_i.wr(PDLC_ADDR_FUNC, fw(2'b00, 1'b0, 1'b1));
    for (int k = 0; k < 8; k++) begin
      seed = nx(seed);
      @(posedge mclk);
      phase_cmp_raw <= seed[0];
      st(3);
      chk(lock_indicator, seed[0]);
    end
    close_out();
  end
endmodule : pdlc_top_tb
